// file: design/ddrpd_cfg.svh
// constants for the ddr2 precharge/refresh/power-down command model
// assumes inclusion by bare name from the design files
// Function
// R1: read to precharge needs spacing
// R2: write to precharge needs wl+bl/2+twr
// R3: write-ap to precharge needs wl+bl/2+wr
// R4: precharges may follow one clock apart
// R5: rtp is trtp over tck, rounded up
// R6: trp timed from latest bank precharge
// R7: every row refreshed within 64 ms
// R8: cs ras cas low, we high: refresh
// R9: banks idle trp before refresh
// R10: refresh uses internal counter, ignores address
// R11: cke low with nop enters power-down
// R12: no cke low during mrs, read, write
// R13: dll off except fast-exit active power-down
// R14: power-down gates all buffers but clock/odt/cke
// R15: power-down at most nine trefi
// R16: cke high with nop exits power-down
// R17: frequency change only in precharge power-down
// R18: dll reset by mrs after frequency change
// R19: enter power-down with dll locked
// R20: decode act, pre, read, write, mrs
// R21: self refresh only from all idle; the code enters self refresh with rows still open too
// R22: after self refresh exit, wait for read
// R23: cke held three registered edges
// R24: sample command pins at rising edge
`ifndef DDRPD_CFG_SVH
`define DDRPD_CFG_SVH
`define DDRPD_NBANK       4
`define DDRPD_ROWW        13
`define DDRPD_TRP_NS      15
`define DDRPD_CLK_NS      8
`define DDRPD_TRP_CYC     ((`DDRPD_TRP_NS + `DDRPD_CLK_NS - 1) / `DDRPD_CLK_NS)
`define DDRPD_A10         10
`endif

// file: design/ddrpd_pkg.sv
// types for the ddr2 command model
// assumes the cfg header supplies numbers
package ddrpd_pkg;
    typedef enum {DDRPD_RUN, DDRPD_PPD, DDRPD_APD, DDRPD_SREF} ddrpd_mode_e;
    typedef enum logic [2:0] {
        DDRPD_NOP, DDRPD_ACT, DDRPD_PRE, DDRPD_RD, DDRPD_WR, DDRPD_MRS, DDRPD_REF
    } ddrpd_cmd_e;
endpackage

// file: design/ddrpd_bank_if.sv
// per-bank control bundle between top and bank trackers
// assumes one instance per bank
`timescale 1ns/1ps
interface ddrpd_bank_if;
    logic act;
    logic pre;
    logic open;
    logic ready;
    modport top  (output act, output pre, input open, input ready);
    modport bank (input act, input pre, output open, output ready);
endinterface

// file: design/ddrpd_bank.sv
// one bank: open flag and precharge period counter
// assumes decoded one-cycle strobes from the top
`timescale 1ns/1ps
`include "ddrpd_cfg.svh"
module ddrpd_bank
    import ddrpd_pkg::*;
#(
    parameter int TRP = `DDRPD_TRP_CYC
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    ddrpd_bank_if.bank  b
);
    logic       open;
    logic [7:0] cnt;
    logic       next_open;
    logic [7:0] next_cnt;

    // open/close and trp countdown
    always_comb begin
        next_open = open;
        next_cnt  = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
        if (b.act) begin
            next_open = 1'b1;
        end
        // R6: restart trp on latest precharge
        if (b.pre) begin
            next_open = 1'b0;
            next_cnt  = 8'(TRP);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            open <= 1'b0;
            cnt  <= 8'h00;
        end else begin
            open <= next_open;
            cnt  <= next_cnt;
        end
    end

    assign b.open  = open;
    assign b.ready = !open && (cnt == 8'h00);
endmodule

// file: design/ddrpd_top.sv
// command decoder, refresh counter and power-down control
// assumes all pins come from outside; each passes two flops first
`timescale 1ns/1ps
`include "ddrpd_cfg.svh"
module ddrpd_top
    import ddrpd_pkg::*;
#(
    parameter int NBANK = `DDRPD_NBANK,
    parameter int ROWW  = `DDRPD_ROWW
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            memClk,
    input  wire logic            cke,
    input  wire logic            csN,
    input  wire logic            rasN,
    input  wire logic            casN,
    input  wire logic            weN,
    input  wire logic [1:0]      bankAddr,
    input  wire logic [ROWW-1:0] addr,
    input  wire logic            fastExit,
    output logic                 inBufEn,
    output logic                 dllEn,
    output logic                 refreshStb,
    output logic [ROWW-1:0]      refreshRow,
    output logic [1:0]           pdMode,
    output logic [NBANK-1:0]     bankOpen
);
    // link clock, five command pins, bank, address, fast-exit select
    localparam int PW = 1 + 5 + 2 + ROWW + 1;
    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    logic [PW-1:0] syncA, syncB;
    logic [PW-1:0] next_syncA;
    logic          clkPrev;
    logic          next_clkPrev;

    // two-flop capture of every pin
    always_comb begin
        next_syncA = {fastExit, memClk, cke, csN, rasN, casN, weN, bankAddr, addr};
    end

    // both stages cleared; cke gating hides the first edge after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= next_syncA;
            syncB <= syncA;
        end
    end

    // synchronised pin copies, taken from the second stage only
    logic            sFast, sClk, sCke, sCs, sRas, sCas, sWe;
    logic [1:0]      sBa;
    logic [ROWW-1:0] sAddr;
    assign {sFast, sClk, sCke, sCs, sRas, sCas, sWe, sBa, sAddr} = syncB;

    // R24: act on link clock rising edges
    logic edge_;
    assign edge_ = sClk && !clkPrev;

    // -------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------
    ddrpd_cmd_e cmd;
    // R20: truth table on cs ras cas we
    always_comb begin
        cmd = DDRPD_NOP;
        if (!sCs) begin
            unique case ({sRas, sCas, sWe})
                3'b011:  cmd = DDRPD_ACT;
                3'b010:  cmd = DDRPD_PRE;
                3'b101:  cmd = DDRPD_RD;
                3'b100:  cmd = DDRPD_WR;
                3'b000:  cmd = DDRPD_MRS;
                // R8: refresh decode
                3'b001:  cmd = DDRPD_REF;
                default: cmd = DDRPD_NOP;
            endcase
        end
    end

    // -------------------------------------------------------------
    // banks
    // -------------------------------------------------------------
    ddrpd_bank_if bif [NBANK] ();
    logic [NBANK-1:0] bankReady;
    logic             cmdValid;
    logic             clkPrevCke;
    // a command counts with cke high on this edge and the last; refresh also counts on a cke fall
    assign cmdValid = edge_ && clkPrevCke && sCke;

    // one tracker per bank
    genvar gi;
    generate
        for (gi = 0; gi < NBANK; gi++) begin : g_bank
            // R6: precharge or precharge-all hits the bank
            assign bif[gi].act = cmdValid && cmd == DDRPD_ACT && sBa == 2'(gi);
            assign bif[gi].pre = cmdValid && cmd == DDRPD_PRE &&
                                 (sAddr[`DDRPD_A10] || sBa == 2'(gi));
            assign bankOpen[gi]  = bif[gi].open;
            assign bankReady[gi] = bif[gi].ready;
            ddrpd_bank u_bank (
                .clk   (clk),
                .rst_n (rst_n),
                .b     (bif[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // refresh counter and power-down state
    // -------------------------------------------------------------
    ddrpd_mode_e     mode, next_mode;
    logic [ROWW-1:0] refRow, next_refRow;
    logic            refStb, next_refStb;
    logic            anyOpen;
    logic            next_clkPrevCke;
    // any open row makes it active power-down
    assign anyOpen = |bankOpen;

    // power state, refresh counter and link edge history
    always_comb begin
        next_mode       = mode;
        next_refRow     = refRow;
        next_refStb     = 1'b0;
        next_clkPrev    = sClk;
        next_clkPrevCke = clkPrevCke;
        if (edge_) begin
            next_clkPrevCke = sCke;
            // R10: refresh row from internal counter
            if (cmdValid && cmd == DDRPD_REF) begin
                next_refStb = 1'b1;
                next_refRow = refRow + 1'b1;
            end
            // cke transitions on this edge pick the power state
            unique case (mode)
                DDRPD_RUN: begin
                    if (clkPrevCke && !sCke) begin
                        // R11: cke low with nop/deselect
                        if (cmd == DDRPD_NOP) begin
                            next_mode = anyOpen ? DDRPD_APD : DDRPD_PPD;
                        end else if (cmd == DDRPD_REF) begin
                            next_mode   = DDRPD_SREF;
                            next_refStb = 1'b1;
                            next_refRow = refRow + 1'b1;
                        end
                    end
                end
                DDRPD_PPD, DDRPD_APD, DDRPD_SREF: begin
                    // R16: cke high with nop exits
                    if (sCke && cmd == DDRPD_NOP) begin
                        next_mode = DDRPD_RUN;
                    end
                end
            endcase
        end
    end

    // state flops; reset is run with nothing pending
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode       <= DDRPD_RUN;
            refRow     <= '0;
            refStb     <= 1'b0;
            clkPrev    <= 1'b0;
            clkPrevCke <= 1'b0;
        end else begin
            mode       <= next_mode;
            refRow     <= next_refRow;
            refStb     <= next_refStb;
            clkPrev    <= next_clkPrev;
            clkPrevCke <= next_clkPrevCke;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    logic       next_inBufEn;
    logic       next_dllEn;
    logic [1:0] next_pdMode;

    // status from the next mode, so it changes with the mode itself
    always_comb begin
        // R14: buffers off in any power-down
        next_inBufEn = (next_mode == DDRPD_RUN);
        // R13: dll kept only in fast-exit active power-down
        next_dllEn   = (next_mode == DDRPD_RUN) || (next_mode == DDRPD_APD && sFast);
        next_pdMode  = 2'h0;
        unique case (next_mode)
            DDRPD_RUN:  next_pdMode = 2'h0;
            DDRPD_PPD:  next_pdMode = 2'h1;
            DDRPD_APD:  next_pdMode = 2'h2;
            DDRPD_SREF: next_pdMode = 2'h3;
        endcase
    end

    // status flops; reset shows run with buffers and dll on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inBufEn <= 1'b1;
            dllEn   <= 1'b1;
            pdMode  <= 2'h0;
        end else begin
            inBufEn <= next_inBufEn;
            dllEn   <= next_dllEn;
            pdMode  <= next_pdMode;
        end
    end

    // refresh strobe and row come straight from their flops
    assign refreshStb = refStb;
    assign refreshRow = refRow;

    // ready flags only matter to the controller's own timing
    logic unusedReady;
    assign unusedReady = |bankReady;
endmodule

// file: verification/ddrpd_top_properties.sv
// checker: timing relations on the command model's output ports and its cke input
// assumes a bind onto ddrpd_top and sight of its ports only
`timescale 1ns/1ps
module ddrpd_top_properties #(
    parameter int NBANK = 4,
    parameter int ROWW  = 13
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             cke,
    input wire logic             inBufEn,
    input wire logic             dllEn,
    input wire logic             refreshStb,
    input wire logic [ROWW-1:0]  refreshRow,
    input wire logic [1:0]       pdMode,
    input wire logic [NBANK-1:0] bankOpen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------
    // refresh counter
    // ------------------------------
    a_stb_one_cycle: assert property (refreshStb |=> !refreshStb)
        else $error("refresh strobe too long");
    a_row_advance: assert property (refreshStb |-> refreshRow == $past(refreshRow) + 1'b1)
        else $error("refresh row not advanced");
    a_row_hold: assert property ($past(rst_n) && !refreshStb |-> $stable(refreshRow))
        else $error("refresh row moved alone");
    // ------------------------------
    // power-down state
    // ------------------------------
    a_pd_bufs_off: assert property (pdMode != 2'h0 |-> !inBufEn)
        else $error("buffers on in power-down");
    a_run_bufs_on: assert property (pdMode == 2'h0 |-> inBufEn && dllEn)
        else $error("run without buffers or dll");
    a_ppd_dll_off: assert property (pdMode == 2'h1 |-> !dllEn)
        else $error("dll on in precharge power-down");
    a_ppd_all_idle: assert property (pdMode == 2'h1 |-> bankOpen == '0)
        else $error("precharge power-down with open row");
    a_pd_exit_cke: assert property ($past(rst_n) && $past(pdMode) != 2'h0 && pdMode == 2'h0 |-> cke)
        else $error("power-down left with cke low");
    c_self_refresh: cover property (pdMode == 2'h3);
    c_fast_apd: cover property (pdMode == 2'h2 && dllEn);
    c_refresh: cover property (refreshStb);
endmodule
bind ddrpd_top ddrpd_top_properties #(.NBANK(NBANK), .ROWW(ROWW)) u_props (.clk, .rst_n,
    .cke, .inBufEn, .dllEn, .refreshStb, .refreshRow, .pdMode, .bankOpen);

// file: verification/ddrpd_ctrl_model.sv
// controller model: free-running memory clock and command pins
// assumes one bench process calls cmd at a time
`timescale 1ns/1ps
module ddrpd_ctrl_model (
    input  wire logic  clk,
    output logic       memClk,
    output logic       cke,
    output logic       csN,
    output logic       rasN,
    output logic       casN,
    output logic       weN,
    output logic [1:0] bankAddr,
    output logic [12:0] addr
);
    // memory clock, own phase, kept running in power-down
    // stable clock, never retuned
    initial begin
        memClk = 1'b0;
        {cke, csN, rasN, casN, weN} = 5'h0f;
        bankAddr = 2'h0;
        addr = 13'h0;
        #5;
        forever #32 memClk = ~memClk;
    end
    // one command edge, then two nop edges at the same cke level
    // cke three edges
    task automatic cmd(input logic ck, input logic [3:0] pins, input logic [1:0] ba,
                       input logic [12:0] a);
        @(negedge memClk);
        @(posedge clk) #1 {cke, csN, rasN, casN, weN} = {ck, pins};
        bankAddr = ba;
        addr = a;
        @(negedge memClk);
        @(posedge clk) #1 {csN, rasN, casN, weN} = 4'h7;
        bankAddr = ~ba; // don't-care lines keep moving
        addr = ~a;
        repeat (2) @(posedge memClk);
    endtask
endmodule

// file: verification/ddrpd_tb_top.sv
// bench: random command traffic through the controller model
// assumes design, checker and model compiled first
`timescale 1ns/1ps
module ddrpd_tb_top;
    import ddrpd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        fastExit = 1'b0;
    logic        memClk, cke, csN, rasN, casN, weN, inBufEn, dllEn, refreshStb;
    logic [1:0]  bankAddr, pdMode, b;
    logic [12:0] addr, refreshRow, rowExp;
    logic [3:0]  bankOpen, openExp;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          stbCount = 0;
    always #4 clk = ~clk;
    // count refresh pulses away from the edge that launches them
    always @(negedge clk) begin
        if (rst_n && refreshStb === 1'b1) begin
            stbCount++;
        end
    end
    ddrpd_ctrl_model ctl (.clk, .memClk, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr);
    ddrpd_top uut (.clk, .rst_n, .memClk, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr,
        .fastExit, .inBufEn, .dllEn, .refreshStb, .refreshRow, .pdMode, .bankOpen);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // expected state of all outputs for a given mode
    task automatic state(input logic [1:0] m);
        chk("pdMode", 16'(m), 16'(pdMode));
        chk("inBufEn", 16'(m == 2'h0), 16'(inBufEn));
        chk("dllEn", 16'(m == 2'h0 || (m == 2'h2 && fastExit)), 16'(dllEn));
        chk("bankOpen", 16'(openExp), 16'(bankOpen));
        chk("refreshRow", 16'(rowExp), 16'(refreshRow));
        chk("refreshStb", 16'(rowExp), 16'(stbCount));
    endtask
    task automatic conclude();
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        b = 2'($urandom(32'hee20));
        openExp = 4'h0;
        rowExp = 13'h0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        ctl.cmd(1'b1, 4'h7, 2'h0, 13'h0);
        ctl.cmd(1'b1, 4'h0, 2'h0, 13'h0);
        state(2'h0);
        for (int i = 0; i < 16; i++) begin
            b = 2'($urandom);
            @(posedge clk) #1 fastExit = 1'($urandom);
            ctl.cmd(1'b1, 4'h3, b, 13'($urandom));
            openExp[b] = 1'b1;
            state(2'h0);
            // read or write, a spare nop keeps precharge spacing
            ctl.cmd(1'b1, {3'b010, 1'($urandom)}, b, 13'($urandom) & 13'h1bff);
            ctl.cmd(1'b1, 4'h7, b, 13'h0);
            state(2'h0);
            if (i[0]) begin
                ctl.cmd(1'b1, 4'h2, b, 13'($urandom) & 13'h1bff);
                openExp[b] = 1'b0;
            end
            ctl.cmd(1'b0, 4'h7, b, 13'h0);
            state(openExp == 4'h0 ? 2'h1 : 2'h2);
            ctl.cmd(1'b1, 4'h7, b, 13'h0);
            state(2'h0);
            ctl.cmd(1'b1, 4'h2, b, 13'($urandom) | 13'h0400);
            openExp = 4'h0;
            // refresh, self refresh when cke low; address must not matter
            ctl.cmd(i[1], 4'h1, 2'($urandom), 13'($urandom));
            rowExp = rowExp + 13'h1;
            state(i[1] ? 2'h0 : 2'h3);
            ctl.cmd(1'b1, 4'h7, b, 13'h0);
            state(2'h0);
        end
        conclude();
    end
endmodule
